// ==== include/rst_int_regs.vh ====
// Constants for the reset-source and interrupt-entry unit
// Function
// - RC delay detector raises system reset when processor clock edges stop
// - Clock-failure reset happens only while clock_watch_enable is set
// - E clock under 10 kHz always fails; at or above 200 kHz never
// - Clock-failure reset drives the bidirectional reset pin low
// - Clock-failure reset has its own vector, apart from watchdog and external
// - Special modes bring disable_watch_resets up at 1; writing 0 re-enables
// - Normal modes hold disable_watch_resets at 0; writing 1 has no effect
// - With halt_block_flag set, stop acts as no-operation, clocks keep running
// - Clocks not restarting after clock failure keep the reset pin low
// - External pin low starts the same reset sequence; held past drive time
// - Every reset drives the pin low at least four E-clock cycles
// - Pin sampled two cycles after release; low means external cause
// - Every reset reinitializes registers; causes differ only in vector
// - Pin high at sample: clock failure, then watchdog, else normal vector
// - Pin unable to rise within two cycles makes every reset external
// - Interrupt taken after instruction ends; stack all, load top vector
// - Return from handler restores registers and both mask bits
// - General mask flag blocks all maskable sources besides local enables
// - Reset sets both the nmi mask bit and the general mask flag
// - Transfer may clear the nmi mask bit but never set it; return loads it from rti_flags
// - The nmi pin outranks every maskable source
// - Maskable entry sets general mask after stacking flags, nmi mask kept
// - Nmi entry sets both mask bits after the flags byte is stacked
// - Push order: PC lo, hi, Y lo, hi, X lo, hi, A, B, flags
`ifndef RST_INT_REGS_VH
`define RST_INT_REGS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define CTRL_ADDR 2'h0
`define STAT_ADDR 2'h1
`define FLAGS_ADDR 2'h2
`define CME_BIT 0
`define DISABLE_WATCH_RESETS_BIT 1

// ----------------------------------------
// Flags byte layout
// ----------------------------------------
`define HALT_BLOCK_BIT 7
`define NMI_MASK_BIT 6
`define GEN_MASK_BIT 4
`define FLAGS_RESET 8'hD0

// ----------------------------------------
// Reset timing and causes
// ----------------------------------------
`define DRIVE_CYCLES 3'h4
`define SAMPLE_DELAY 3'h2
`define SYNC_DEPTH 3'h2
`define CLK_FAIL_KHZ 32'h0000_000A
`define CLK_SAFE_KHZ 32'h0000_00C8
`define CAUSE_NORMAL 2'h0
`define CAUSE_CLKFAIL 2'h1
`define CAUSE_WATCHDOG 2'h2
`define CAUSE_EXTERNAL 2'h3

// ----------------------------------------
// Vectors
// ----------------------------------------
`define VEC_EXTERNAL 16'hFFFE
`define VEC_CLKFAIL 16'hFFFC
`define VEC_WATCHDOG 16'hFFFA
`define VEC_NMI 16'hFFF4
`define VEC_IRQ_TOP 16'hFFF2
`define PUSH_LAST 4'h8

`endif

// ==== src/rst_int_unit.v ====
// Reset sequencer, clock-failure latch and interrupt entry control
`timescale 1ns/100ps
`default_nettype none
`include "rst_int_regs.vh"

module rst_int_unit #(
   parameter IRQ_N = 8
) (
   input wire clk,
   input wire rstn,
   input wire [1:0] addr,
   input wire [7:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output reg [7:0] rdata,
   input wire special_mode,
   input wire rc_expired,
   input wire watchdog_fail,
   input wire rst_pin_in,
   output reg rst_pin_out,
   output reg rst_pin_oe_n,
   output reg sys_reset,
   output reg [15:0] reset_vec,
   output reg reset_vec_valid,
   input wire instr_done,
   input wire nmi_pin_n,
   input wire [IRQ_N-1:0] irq_req,
   input wire [15:0] pc,
   input wire [15:0] iy,
   input wire [15:0] ix,
   input wire [7:0] acc_a,
   input wire [7:0] acc_b,
   input wire tap_exec,
   input wire rti_exec,
   input wire [7:0] rti_flags,
   input wire stop_exec,
   output reg stop_clocks,
   output reg int_busy,
   output reg push_valid,
   output reg [7:0] push_data,
   output reg int_vec_load,
   output reg [15:0] int_vec,
   output reg [7:0] flags
);

   // ----------------------------------------
   // State codes
   // ----------------------------------------
   localparam RS_RUN = 3'd0;
   localparam RS_DRIVE = 3'd1;
   localparam RS_WAIT = 3'd2;
   localparam RS_HOLD = 3'd3;
   localparam RS_VEC = 3'd4;
   localparam IS_IDLE = 2'd0;
   localparam IS_PUSH = 2'd1;
   localparam IS_RESOLVE = 2'd2;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   reg cme_q;
   reg disable_watch_resets_q;
   reg strap_done_q;
   reg cf_q;
   reg wd_q;
   reg pin_meta_q;
   reg pin_sync_q;
   reg [2:0] rs_q;
   reg [2:0] cnt_q;
   reg [1:0] cause_q;
   reg [1:0] is_q;
   reg [3:0] idx_q;
   reg nmi_entry_q;
   reg [15:0] irq_vec_q;
   wire cf_trig;
   wire vec_done;
   wire nmi_pend;
   wire irq_pend;
   wire [IRQ_N-1:0] irq_live;
   wire [15:0] irq_vec;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function [15:0] irq_vector;
      input [IRQ_N-1:0] req;
      integer k;
      reg found;
      begin
         irq_vector = `VEC_IRQ_TOP;
         found = 1'b0;
         for (k = 0; k < IRQ_N; k = k + 1) begin
            if (req[k] && !found) begin
               found = 1'b1;
               irq_vector = `VEC_IRQ_TOP - {k[14:0], 1'b0};
            end
         end
      end
   endfunction

   function [7:0] push_byte;
      input [3:0] i;
      input [15:0] p;
      input [15:0] y;
      input [15:0] x;
      input [7:0] a;
      input [7:0] b;
      input [7:0] f;
      begin
         case (i)
            4'h0: push_byte = p[7:0];
            4'h1: push_byte = p[15:8];
            4'h2: push_byte = y[7:0];
            4'h3: push_byte = y[15:8];
            4'h4: push_byte = x[7:0];
            4'h5: push_byte = x[15:8];
            4'h6: push_byte = a;
            4'h7: push_byte = b;
            default: push_byte = f;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Clock-failure detection
   // ----------------------------------------
   // gated detector
   // RC cell threshold lies between CLK_FAIL_KHZ and CLK_SAFE_KHZ
   assign cf_trig = rc_expired & cme_q & ~disable_watch_resets_q;
   assign vec_done = (rs_q == RS_VEC);

   always @(posedge clk or negedge rstn or posedge cf_trig) begin
      if (!rstn) begin
         cf_q <= 1'b0;
      end else if (cf_trig) begin
         cf_q <= 1'b1;
      end else if (vec_done) begin
         cf_q <= 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wd_q <= 1'b0;
      end else if (watchdog_fail && !disable_watch_resets_q) begin
         wd_q <= 1'b1;
      end else if (vec_done) begin
         wd_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Reset pin synchronizer
   // ----------------------------------------
   // two-stage synchronizer
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta_q <= 1'b1;
         pin_sync_q <= 1'b1;
      end else begin
         pin_meta_q <= rst_pin_in;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ----------------------------------------
   // Reset pin driver
   // ----------------------------------------
   // clock failure pulls pin low at once
   // low stays while clocks are stopped
   always @(posedge clk or negedge rstn or posedge cf_trig) begin
      if (!rstn) begin
         rst_pin_oe_n <= 1'b0;
      end else if (cf_trig) begin
         rst_pin_oe_n <= 1'b0;
      end else if (rs_q == RS_RUN) begin
         rst_pin_oe_n <= ~(cf_q | wd_q | ~pin_sync_q);
      end else if (rs_q == RS_DRIVE) begin
         rst_pin_oe_n <= (cnt_q == `DRIVE_CYCLES - 3'h1);
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_pin_out <= 1'b0;
      end else begin
         rst_pin_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // Reset sequencer
   // ----------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rs_q <= RS_DRIVE;
         cnt_q <= 3'h0;
         cause_q <= `CAUSE_NORMAL;
         sys_reset <= 1'b1;
         reset_vec <= `VEC_EXTERNAL;
         reset_vec_valid <= 1'b0;
      end else begin
         reset_vec_valid <= 1'b0;
         case (rs_q)
            RS_RUN: begin
               cnt_q <= 3'h0;
               // pin low starts the common sequence
               if (cf_q || wd_q || !pin_sync_q) begin
                  rs_q <= RS_DRIVE;
                  sys_reset <= 1'b1;
               end
            end
            RS_DRIVE: begin
               // at least four cycles of drive
               if (cnt_q == `DRIVE_CYCLES - 3'h1) begin
                  rs_q <= RS_WAIT;
                  cnt_q <= 3'h0;
               end else begin
                  cnt_q <= cnt_q + 3'h1;
               end
            end
            RS_WAIT: begin
               // sample pin two cycles after release
               if (cnt_q == `SAMPLE_DELAY + `SYNC_DEPTH - 3'h1) begin
                  cnt_q <= 3'h0;
                  if (!pin_sync_q) begin
                     cause_q <= `CAUSE_EXTERNAL;
                     rs_q <= RS_HOLD;
                  end else begin
                     rs_q <= RS_VEC;
                     // clock failure, then watchdog, then normal
                     if (cf_q) begin
                        cause_q <= `CAUSE_CLKFAIL;
                     end else if (wd_q) begin
                        cause_q <= `CAUSE_WATCHDOG;
                     end else begin
                        cause_q <= `CAUSE_NORMAL;
                     end
                  end
               end else begin
                  cnt_q <= cnt_q + 3'h1;
               end
            end
            RS_HOLD: begin
               if (pin_sync_q) begin
                  rs_q <= RS_VEC;
               end
            end
            RS_VEC: begin
               case (cause_q)
                  `CAUSE_CLKFAIL: reset_vec <= `VEC_CLKFAIL;
                  `CAUSE_WATCHDOG: reset_vec <= `VEC_WATCHDOG;
                  default: reset_vec <= `VEC_EXTERNAL;
               endcase
               reset_vec_valid <= 1'b1;
               sys_reset <= 1'b0;
               rs_q <= RS_RUN;
            end
            default: begin
               rs_q <= RS_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Control register and mode strap
   // ----------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cme_q <= 1'b0;
         disable_watch_resets_q <= 1'b0;
         strap_done_q <= 1'b0;
      end else if (!strap_done_q || sys_reset) begin
         // special mode starts with resets blocked
         strap_done_q <= 1'b1;
         cme_q <= 1'b0;
         disable_watch_resets_q <= special_mode;
      end else if (wr_en && addr == `CTRL_ADDR) begin
         cme_q <= wdata[`CME_BIT];
         // forced to 0 outside special mode
         disable_watch_resets_q <= special_mode & wdata[`DISABLE_WATCH_RESETS_BIT];
      end else if (!special_mode) begin
         disable_watch_resets_q <= 1'b0;
      end
   end

   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            `CTRL_ADDR: rdata <= {6'h00, disable_watch_resets_q, cme_q};
            `STAT_ADDR: rdata <= {3'h0, wd_q, cf_q, sys_reset, cause_q};
            `FLAGS_ADDR: rdata <= flags;
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // Interrupt pending terms
   // ----------------------------------------
   // general mask blocks maskable sources
   assign irq_live = irq_req & {IRQ_N{~flags[`GEN_MASK_BIT]}};
   assign irq_pend = |irq_live;
   assign nmi_pend = ~nmi_pin_n & ~flags[`NMI_MASK_BIT];
   assign irq_vec = irq_vector(irq_req);

   // ----------------------------------------
   // Interrupt entry sequencer
   // ----------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         is_q <= IS_IDLE;
         idx_q <= 4'h0;
         int_busy <= 1'b0;
         push_valid <= 1'b0;
         push_data <= 8'h00;
         int_vec_load <= 1'b0;
         int_vec <= `VEC_NMI;
         nmi_entry_q <= 1'b0;
         irq_vec_q <= `VEC_IRQ_TOP;
      end else if (sys_reset) begin
         is_q <= IS_IDLE;
         idx_q <= 4'h0;
         int_busy <= 1'b0;
         push_valid <= 1'b0;
         int_vec_load <= 1'b0;
      end else begin
         push_valid <= 1'b0;
         int_vec_load <= 1'b0;
         case (is_q)
            IS_IDLE: begin
               if (instr_done && (nmi_pend || irq_pend)) begin
                  is_q <= IS_PUSH;
                  idx_q <= 4'h0;
                  int_busy <= 1'b1;
               end
            end
            IS_PUSH: begin
               push_valid <= 1'b1;
               push_data <= push_byte(idx_q, pc, iy, ix, acc_a, acc_b,
                  flags);
               if (idx_q == `PUSH_LAST) begin
                  nmi_entry_q <= nmi_pend;
                  irq_vec_q <= irq_vector(irq_live);
                  is_q <= IS_RESOLVE;
               end else begin
                  idx_q <= idx_q + 4'h1;
               end
            end
            IS_RESOLVE: begin
               int_vec <= nmi_entry_q ? `VEC_NMI : irq_vec_q;
               int_vec_load <= 1'b1;
               int_busy <= 1'b0;
               is_q <= IS_IDLE;
            end
            default: begin
               is_q <= IS_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Flags byte and stop control
   // ----------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags <= `FLAGS_RESET;
         stop_clocks <= 1'b0;
      end else if (sys_reset) begin
         flags <= `FLAGS_RESET;
         stop_clocks <= 1'b0;
      end else begin
         stop_clocks <= 1'b0;
         if (is_q == IS_PUSH && idx_q == `PUSH_LAST) begin
            // general mask set after flags stacked
            flags[`GEN_MASK_BIT] <= 1'b1;
            // nmi entry also sets nmi mask
            if (nmi_pend) begin
               flags[`NMI_MASK_BIT] <= 1'b1;
            end
         end else if (rti_exec) begin
            flags <= rti_flags;
         end else if (tap_exec) begin
            flags <= acc_a;
            // nmi mask can only be cleared
            flags[`NMI_MASK_BIT] <= acc_a[`NMI_MASK_BIT] &
               flags[`NMI_MASK_BIT];
         end
         // stop blocked while halt flag set
         if (stop_exec && !flags[`HALT_BLOCK_BIT]) begin
            stop_clocks <= 1'b1;
         end
      end
   end

   // Unused full-list vector of raw requests, reduced to a bit that nothing reads
   wire unused_irq_vec;
   assign unused_irq_vec = ^irq_vec;

endmodule
`default_nettype wire

// ==== test/reset_circuit.sv ====
// External reset circuit: pull-up, wired-low pin, optional slow rise
`timescale 1ns/100ps
`default_nettype none
module reset_circuit (
   input wire logic clk,
   input wire logic oe_n,
   input wire logic drv_out,
   input wire logic ext_low,
   input wire logic slow,
   output logic pin
);
   logic [2:0] rise_q = 3'h0;
   always @(posedge clk) begin
      if (!oe_n || ext_low) begin
         rise_q <= 3'h4;
      end else if (rise_q != 3'h0) begin
         rise_q <= rise_q - 3'h1;
      end
   end
   assign pin = !((!oe_n && !drv_out) || ext_low || (slow && rise_q != 3'h0));
endmodule
`default_nettype wire

// ==== test/rst_int_props.sv ====
// Port assertions for the reset and interrupt entry unit
`timescale 1ns/100ps
`default_nettype none
`include "rst_int_regs.vh"
module rst_int_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic rc_expired,
   input wire logic rst_pin_in,
   input wire logic rst_pin_out,
   input wire logic rst_pin_oe_n,
   input wire logic sys_reset,
   input wire logic [15:0] reset_vec,
   input wire logic reset_vec_valid,
   input wire logic instr_done,
   input wire logic tap_exec,
   input wire logic rti_exec,
   input wire logic [7:0] rti_flags,
   input wire logic stop_exec,
   input wire logic stop_clocks,
   input wire logic int_busy,
   input wire logic push_valid,
   input wire logic int_vec_load,
   input wire logic [15:0] int_vec,
   input wire logic [7:0] flags
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ----------------------------------------
   // Reset pin and interrupt entry
   // ----------------------------------------
   sequence drive_low;
      !rst_pin_oe_n [*4];
   endsequence
   sequence pin_up;
      $rose(rst_pin_oe_n) && !$past(rc_expired) ##0 rst_pin_in [*5];
   endsequence
   sequence nine_push;
      push_valid [*8] ##1 push_valid;
   endsequence
   drive_four_a: assert property ($fell(rst_pin_oe_n) |-> drive_low)
      else $error("reset pin drive too short");
   open_drain_a: assert property (rst_pin_out == 1'b0)
      else $error("reset pin driven high");
   sample_high_a: assert property (pin_up |-> ##1 reset_vec_valid)
      else $error("vector not chosen after sample");
   vec_end_a: assert property ($fell(sys_reset) |-> reset_vec_valid &&
      (reset_vec == `VEC_EXTERNAL || reset_vec == `VEC_CLKFAIL ||
      reset_vec == `VEC_WATCHDOG)) else $error("bad reset vector");
   rst_masks_a: assert property ($fell(sys_reset) |-> flags == `FLAGS_RESET)
      else $error("flags not reset");
   entry_wait_a: assert property ($rose(int_busy) |-> $past(instr_done))
      else $error("entry without instruction end");
   push_order_a: assert property ($rose(int_busy) |-> ##1 nine_push ##1 int_vec_load)
      else $error("push sequence wrong");
   gen_mask_a: assert property (int_vec_load && int_vec != `VEC_NMI |->
      flags[`GEN_MASK_BIT] && flags[`NMI_MASK_BIT] ==
      $past(flags[`NMI_MASK_BIT], 11)) else $error("maskable entry masks");
   nmi_mask_a: assert property (int_vec_load && int_vec == `VEC_NMI |->
      flags[`NMI_MASK_BIT] && flags[`GEN_MASK_BIT])
      else $error("nmi entry masks");
   no_set_x_a: assert property (tap_exec && !flags[`NMI_MASK_BIT] |=>
      !flags[`NMI_MASK_BIT]) else $error("nmi mask set by transfer");
   rti_restore_a: assert property (rti_exec |=> flags == $past(rti_flags))
      else $error("flags not restored");
   stop_nop_a: assert property (stop_exec && flags[`HALT_BLOCK_BIT] |=>
      !stop_clocks) else $error("stop not blocked");
endmodule
bind rst_int_unit rst_int_props rst_int_props_inst (.clk, .rstn, .rc_expired,
   .rst_pin_in, .rst_pin_out, .rst_pin_oe_n, .sys_reset, .reset_vec,
   .reset_vec_valid, .instr_done, .tap_exec, .rti_exec, .rti_flags,
   .stop_exec, .stop_clocks, .int_busy, .push_valid, .int_vec_load,
   .int_vec, .flags);
`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the reset and interrupt entry unit
`timescale 1ns/100ps
`default_nettype none
`include "rst_int_regs.vh"
module tb;
   logic clk = 1'b0, rstn = 1'b0, special_mode = 1'b0, rc_expired = 1'b0;
   logic ext_low = 1'b0, slow = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic rd_d = 1'b0, nmi_pin_n = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [4:0] pls = 5'h00;
   logic [7:0] wdata = 8'h00, irq_req = 8'h00, acc_a = 8'h00, acc_b = 8'h00;
   logic [7:0] rti_flags = 8'h00;
   logic [15:0] pc = 16'h0000, iy = 16'h0000, ix = 16'h0000, r = 16'h005B;
   logic [15:0] v;
   logic [7:0] rdata, push_data, flags;
   logic rst_pin_in, rst_pin_out, rst_pin_oe_n, sys_reset, reset_vec_valid;
   logic stop_clocks, int_busy, push_valid, int_vec_load;
   logic [15:0] reset_vec, int_vec;
   logic [15:0] exp_q[$];
   int num_errors = 0, num_checks = 0, cyc_n = 0, i;
   rst_int_unit rst_int_unit_inst (.clk, .rstn, .addr, .wdata, .wr_en, .rd_en,
      .rdata, .special_mode, .rc_expired, .watchdog_fail(pls[0]), .rst_pin_in,
      .rst_pin_out, .rst_pin_oe_n, .sys_reset, .reset_vec, .reset_vec_valid,
      .instr_done(pls[1]), .nmi_pin_n, .irq_req, .pc, .iy, .ix, .acc_a, .acc_b,
      .tap_exec(pls[2]), .rti_exec(pls[3]), .rti_flags, .stop_exec(pls[4]),
      .stop_clocks, .int_busy, .push_valid, .push_data, .int_vec_load, .int_vec,
      .flags);
   reset_circuit reset_circuit_inst (.clk, .oe_n(rst_pin_oe_n),
      .drv_out(rst_pin_out), .ext_low, .slow, .pin(rst_pin_in));
   always #2 clk = ~clk;
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic take(input logic [15:0] got);
      if (exp_q.size() == 0) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=none", $time, got);
      end else begin
         chk(got, exp_q.pop_front());
      end
   endtask
   task automatic give_verdict();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(input logic [4:0] m);
      @(posedge clk);
      pls <= m;
      @(posedge clk);
      pls <= 5'h00;
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      exp_q.push_back({8'h00, e});
      @(posedge clk);
      rd_en <= 1'b0;
   endtask
   task automatic settle();
      int n = 0;
      while (sys_reset !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      while (sys_reset !== 1'b0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      tick(2);
   endtask
   task automatic por(input logic sm);
      rstn <= 1'b0;
      special_mode <= sm;
      exp_q.push_back(`VEC_EXTERNAL);
      tick(16);
      rstn <= 1'b1;
      settle();
   endtask
   task automatic entry(input logic [15:0] vec, input logic [7:0] f);
      logic [15:0] p, y, x, ab;
      logic [7:0] b[9];
      int n = 0;
      p = lfsr(r);
      y = lfsr(p);
      x = lfsr(y);
      ab = lfsr(x);
      r = ab;
      pc <= p;
      iy <= y;
      ix <= x;
      {acc_a, acc_b} <= ab;
      b = '{p[7:0], p[15:8], y[7:0], y[15:8], x[7:0], x[15:8], ab[15:8],
         ab[7:0], f};
      foreach (b[k]) exp_q.push_back({8'h00, b[k]});
      exp_q.push_back(vec);
      pulse(5'h02);
      tick(2);
      while (int_busy !== 1'b0 && n < 30) begin
         @(posedge clk);
         n++;
      end
      tick(2);
   endtask
   // ----------------------------------------
   // Result watcher and time limit
   // ----------------------------------------
   always @(posedge clk) begin
      rd_d <= rd_en;
      cyc_n++;
      if (cyc_n == 20000) begin
         num_errors++;
         give_verdict();
      end
      if (reset_vec_valid === 1'b1) take(reset_vec);
      if (push_valid === 1'b1) take({8'h00, push_data});
      if (int_vec_load === 1'b1) take(int_vec);
      if (rd_d) take({8'h00, rdata});
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      por(1'b0);
      rd(`FLAGS_ADDR, 8'hD0);
      $display("done: power-on");
      exp_q.push_back(`VEC_WATCHDOG);
      pulse(5'h01);
      settle();
      rd(`STAT_ADDR, 8'h02);
      exp_q.push_back(`VEC_EXTERNAL);
      ext_low <= 1'b1;
      pulse(5'h01);
      tick(40);
      ext_low <= 1'b0;
      settle();
      rd(`STAT_ADDR, 8'h03);
      slow <= 1'b1;
      exp_q.push_back(`VEC_EXTERNAL);
      pulse(5'h01);
      settle();
      slow <= 1'b0;
      rd(`STAT_ADDR, 8'h03);
      $display("done: reset causes");
      wr(`CTRL_ADDR, 8'h01);
      exp_q.push_back(`VEC_CLKFAIL);
      rc_expired <= 1'b1;
      repeat (4) begin
         @(negedge clk);
         chk({15'h0000, rst_pin_oe_n}, 16'h0000);
      end
      @(posedge clk);
      rc_expired <= 1'b0;
      settle();
      rd(`CTRL_ADDR, 8'h00);
      wr(`CTRL_ADDR, 8'h01);
      exp_q.push_back(`VEC_CLKFAIL);
      rc_expired <= 1'b1;
      pulse(5'h01);
      tick(8);
      rc_expired <= 1'b0;
      settle();
      rc_expired <= 1'b1;
      tick(10);
      @(negedge clk);
      chk({15'h0000, sys_reset}, 16'h0000);
      @(posedge clk);
      rc_expired <= 1'b0;
      $display("done: clock failure");
      por(1'b1);
      rd(`CTRL_ADDR, 8'h02);
      pulse(5'h01);
      tick(20);
      @(negedge clk);
      chk({15'h0000, sys_reset}, 16'h0000);
      wr(`CTRL_ADDR, 8'h00);
      exp_q.push_back(`VEC_WATCHDOG);
      pulse(5'h01);
      settle();
      por(1'b0);
      wr(`CTRL_ADDR, 8'h02);
      rd(`CTRL_ADDR, 8'h00);
      $display("done: special modes");
      irq_req <= 8'hFF;
      nmi_pin_n <= 1'b0;
      pulse(5'h02);
      tick(15);
      nmi_pin_n <= 1'b1;
      acc_a <= 8'h00;
      pulse(5'h04);
      rd(`FLAGS_ADDR, 8'h00);
      acc_a <= 8'hFF;
      pulse(5'h04);
      rd(`FLAGS_ADDR, 8'hBF);
      pulse(5'h10);
      pulse(5'h08);
      rd(`FLAGS_ADDR, 8'h00);
      pulse(5'h10);
      @(negedge clk);
      chk({15'h0000, stop_clocks}, 16'h0001);
      r = lfsr(r);
      v = {8'h00, r[7:0] | 8'h80};
      irq_req <= v[7:0];
      i = 0;
      while (!v[i]) i++;
      entry(`VEC_IRQ_TOP - 16'(2 * i), 8'h00);
      rd(`FLAGS_ADDR, 8'h10);
      pulse(5'h08);
      rd(`FLAGS_ADDR, 8'h00);
      nmi_pin_n <= 1'b0;
      tick(3);
      entry(`VEC_NMI, 8'h00);
      rd(`FLAGS_ADDR, 8'h50);
      nmi_pin_n <= 1'b1;
      $display("done: interrupts");
      tick(4);
      if (exp_q.size() != 0) num_errors++;
      give_verdict();
   end
endmodule
`default_nettype wire
